// ---- core/atc_pkg.sv ----
// register map, field layout and mode codes of the 8-bit async timer
// assumes a byte-wide register port on the system clock
package atc_pkg;

  // =====================================================================
  // register offsets
  localparam logic [7:0] ATC_OFS_CONTROL_A = 8'hB0;
  localparam logic [7:0] ATC_OFS_CONTROL_B = 8'hB1;
  localparam logic [7:0] ATC_OFS_COUNTER = 8'hB2;
  localparam logic [7:0] ATC_OFS_COMPARE_A = 8'hB3;
  localparam logic [7:0] ATC_OFS_COMPARE_B = 8'hB4;
  localparam logic [7:0] ATC_OFS_ASYNC_STATUS = 8'hB6;

  // =====================================================================
  // field layout
  localparam int ATC_CB_FORCE_A = 7;
  localparam int ATC_CB_FORCE_B = 6;
  localparam int ATC_CB_WAVE_HI = 3;
  localparam int ATC_AS_EXT_CLK = 6;
  localparam int ATC_AS_ASYNC_SEL = 5;
  localparam logic [7:0] ATC_CA_READ_MASK = 8'hF3;
  localparam logic [3:0] ATC_CB_KEEP_MASK = 4'hF;
  localparam logic [7:0] ATC_RESET_BYTE = 8'h00;

  // busy flag positions inside the status byte
  localparam int ATC_BUSY_COUNTER = 4;
  localparam int ATC_BUSY_COMPARE_A = 3;
  localparam int ATC_BUSY_COMPARE_B = 2;
  localparam int ATC_BUSY_CONTROL_A = 1;
  localparam int ATC_BUSY_CONTROL_B = 0;

  // =====================================================================
  // counter limits
  localparam logic [7:0] ATC_MAX = 8'hFF;
  localparam logic [7:0] ATC_BOTTOM = 8'h00;
  localparam logic [7:0] ATC_ONE = 8'h01;

  // =====================================================================
  // wave modes
  typedef enum logic [2:0] {
    ATC_MODE_NORMAL = 3'b000,
    ATC_MODE_PHASE_FF = 3'b001,
    ATC_MODE_CLEAR_ON_CMP = 3'b010,
    ATC_MODE_FAST_FF = 3'b011,
    ATC_MODE_RSVD_4 = 3'b100,
    ATC_MODE_PHASE_CMP = 3'b101,
    ATC_MODE_RSVD_6 = 3'b110,
    ATC_MODE_FAST_CMP = 3'b111
  } atc_mode_t;

  // =====================================================================
  // prescaler: tick when the low bits of the divider are all ones
  localparam logic [9:0] ATC_DIV_8 = 10'h007;
  localparam logic [9:0] ATC_DIV_32 = 10'h01F;
  localparam logic [9:0] ATC_DIV_64 = 10'h03F;
  localparam logic [9:0] ATC_DIV_128 = 10'h07F;
  localparam logic [9:0] ATC_DIV_256 = 10'h0FF;
  localparam logic [9:0] ATC_DIV_1024 = 10'h3FF;
  localparam logic [9:0] ATC_DIV_STEP = 10'h001;

  // output action codes
  localparam logic [1:0] ATC_ACT_OFF = 2'b00;
  localparam logic [1:0] ATC_ACT_TOGGLE = 2'b01;
  localparam logic [1:0] ATC_ACT_CLEAR = 2'b10;
  localparam logic [1:0] ATC_ACT_SET = 2'b11;

endpackage : atc_pkg

// ---- core/atc_timer.sv ----
// 8-bit timer/counter with optional oscillator-pin clocking
// assumes one system clock; oscillator pin is sampled, not a clock domain
`timescale 1ns/1ps

// Summary of operation
// - unused control register bits always read back zero
// - three-bit wave mode from control B bit and two control A bits
// - top is 0xFF in modes 0,1,3 and compare A in 2,5,7
// - compare updates immediate in 0,2; at top in 1,5; bottom in 3,7
// - overflow at max in 0,2,3; bottom in 1,5; top in 7
// - force strobe in non-PWM mode applies compare action immediately
// - forced compare raises no compare event and never clears counter
// - both force strobes read back as zero
// - clock select: stop, undivided, or divided by 8 up to 1024
// - counter register gives live read and write access
// - counter write suppresses compare match on next timer tick
// - both compare values compared continuously, driving events and waves
// - external clock buffer on when enabled and async; crystal when disabled
// - async select picks system clock or oscillator pin as source
// - switching async select may leave timer registers undefined
// - async counter write sets counter busy until transferred
// - async compare writes set their busy flag until transferred
// - async control A write sets its busy flag until transferred
// - async control B write sets its busy flag until transferred
// - counter reads live value; control and compare registers read their holding registers
module atc_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // oscillator pin and oscillator control
  input wire logic timer_osc_in_pin,
  output logic crystal_osc_enable,
  output logic ext_clock_buffer_enable,
  // waveform outputs
  output logic wave_out_a,
  output logic wave_out_b,
  // event pulses to the interrupt flag logic
  output logic overflow_event,
  output logic compare_a_event,
  output logic compare_b_event
);
  import atc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl_a_hold;
    logic [7:0] ctrl_a_act;
    logic [3:0] ctrl_b_hold;
    logic [3:0] ctrl_b_act;
    logic [7:0] cnt;
    logic [7:0] cnt_hold;
    logic [7:0] cmpa_hold;
    logic [7:0] cmpa_buf;
    logic [7:0] cmpa_use;
    logic [7:0] cmpb_hold;
    logic [7:0] cmpb_buf;
    logic [7:0] cmpb_use;
    logic ext_clk;
    logic async_sel;
    logic [4:0] busy;
    logic [9:0] presc;
    logic osc_s1;
    logic osc_s2;
    logic osc_prev;
    logic count_down;
    logic block_match;
    logic wave_a;
    logic wave_b;
    logic ovf_ev;
    logic cmpa_ev;
    logic cmpb_ev;
    logic [7:0] rdata;
  } atc_state_t;

  atc_state_t s_reg;
  atc_state_t s_next;

  // =====================================================================
  // mode decode
  atc_mode_t mode;
  logic is_fast;
  logic is_phase;
  logic is_pwm;
  logic [7:0] top;
  logic src_tick;
  logic cnt_tick;
  logic match_a;
  logic match_b;
  logic force_a;
  logic force_b;
  logic wr_a;
  logic wr_b;
  logic wr_cnt;
  logic wr_ca;
  logic wr_cb;
  logic wr_as;
  logic [9:0] div_mask;

  always_comb begin
    mode = atc_mode_t'({s_reg.ctrl_b_act[ATC_CB_WAVE_HI],
                        s_reg.ctrl_a_act[1:0]});
    if (mode == ATC_MODE_RSVD_4 || mode == ATC_MODE_RSVD_6) begin
      mode = ATC_MODE_NORMAL;
    end
    is_fast = (mode == ATC_MODE_FAST_FF) || (mode == ATC_MODE_FAST_CMP);
    is_phase = (mode == ATC_MODE_PHASE_FF) || (mode == ATC_MODE_PHASE_CMP);
    is_pwm = is_fast || is_phase;
    if (mode == ATC_MODE_CLEAR_ON_CMP || mode == ATC_MODE_PHASE_CMP ||
        mode == ATC_MODE_FAST_CMP) begin
      top = s_reg.cmpa_use;
    end else begin
      top = ATC_MAX;
    end
  end

  // =====================================================================
  // timer clock source and prescaler
  always_comb begin
    // pin edge only after two sampling stages
    src_tick = s_reg.async_sel ? (s_reg.osc_s2 & ~s_reg.osc_prev)
                               : 1'b1;
    case (s_reg.ctrl_b_act[2:0])
      3'b010: div_mask = ATC_DIV_8;
      3'b011: div_mask = ATC_DIV_32;
      3'b100: div_mask = ATC_DIV_64;
      3'b101: div_mask = ATC_DIV_128;
      3'b110: div_mask = ATC_DIV_256;
      3'b111: div_mask = ATC_DIV_1024;
      default: div_mask = '0;
    endcase
    if (s_reg.ctrl_b_act[2:0] == 3'b000) begin
      cnt_tick = 1'b0;
    end else begin
      cnt_tick = src_tick && ((s_reg.presc & div_mask) == div_mask);
    end
    match_a = cnt_tick && !s_reg.block_match &&
              (s_reg.cnt == s_reg.cmpa_use);
    match_b = cnt_tick && !s_reg.block_match &&
              (s_reg.cnt == s_reg.cmpb_use);
  end

  // =====================================================================
  // bus write decode
  always_comb begin
    wr_ca = reg_wr && (reg_addr == ATC_OFS_CONTROL_A);
    if (reg_wr && reg_addr == ATC_OFS_CONTROL_B) begin
      wr_cb = 1'b1;
    end else begin
      wr_cb = 1'b0;
    end
    wr_cnt = reg_wr && (reg_addr == ATC_OFS_COUNTER);
    wr_a = reg_wr && (reg_addr == ATC_OFS_COMPARE_A);
    wr_b = reg_wr && (reg_addr == ATC_OFS_COMPARE_B);
    wr_as = reg_wr && (reg_addr == ATC_OFS_ASYNC_STATUS);
    force_a = wr_cb && reg_wdata[ATC_CB_FORCE_A] && !is_pwm;
    force_b = wr_cb && reg_wdata[ATC_CB_FORCE_B] && !is_pwm;
  end

  // action on a compare match for one channel
  function automatic logic wave_match(input logic cur,
                                      input logic [1:0] act,
                                      input logic fast,
                                      input logic phase,
                                      input logic hi_tog,
                                      input logic down);
    logic r;
    r = cur;
    if (act == ATC_ACT_TOGGLE) begin
      if (!(fast || phase) || hi_tog) begin
        r = ~cur;
      end
    end else if (act == ATC_ACT_CLEAR) begin
      r = phase ? down : 1'b0;
    end else if (act == ATC_ACT_SET) begin
      r = phase ? ~down : 1'b1;
    end
    return r;
  endfunction : wave_match

  // =====================================================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.osc_s1 = timer_osc_in_pin;
    s_next.osc_s2 = s_reg.osc_s1;
    s_next.osc_prev = s_reg.osc_s2;
    s_next.ovf_ev = 1'b0;
    s_next.cmpa_ev = 1'b0;
    s_next.cmpb_ev = 1'b0;
    if (src_tick) begin
      s_next.presc = s_reg.presc + ATC_DIV_STEP;
    end

    // counting sequence
    if (cnt_tick) begin
      s_next.block_match = 1'b0;
      if (is_phase) begin
        if (!s_reg.count_down) begin
          if (s_reg.cnt == top) begin
            s_next.count_down = 1'b1;
            s_next.cnt = s_reg.cnt - ATC_ONE;
            s_next.cmpa_use = s_reg.cmpa_buf;
            s_next.cmpb_use = s_reg.cmpb_buf;
          end else begin
            s_next.cnt = s_reg.cnt + ATC_ONE;
          end
        end else if (s_reg.cnt == ATC_BOTTOM) begin
          s_next.count_down = 1'b0;
          s_next.cnt = ATC_ONE;
          s_next.ovf_ev = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - ATC_ONE;
        end
      end else begin
        s_next.count_down = 1'b0;
        if (mode != ATC_MODE_NORMAL && s_reg.cnt == top) begin
          s_next.cnt = ATC_BOTTOM;
          if (is_fast) begin
            s_next.cmpa_use = s_reg.cmpa_buf;
            s_next.cmpb_use = s_reg.cmpb_buf;
          end
        end else begin
          s_next.cnt = s_reg.cnt + ATC_ONE;
        end
        if (mode == ATC_MODE_FAST_CMP) begin
          s_next.ovf_ev = (s_reg.cnt == top);
        end else begin
          s_next.ovf_ev = (s_reg.cnt == ATC_MAX);
        end
      end
      // fast mode bottom action: set for clear-on-match, clear for set
      if (is_fast && s_reg.cnt == top) begin
        if (s_reg.ctrl_a_act[7]) begin
          s_next.wave_a = ~s_reg.ctrl_a_act[6];
        end
        if (s_reg.ctrl_a_act[5]) begin
          s_next.wave_b = ~s_reg.ctrl_a_act[4];
        end
      end
    end

    // compare events and waves
    s_next.cmpa_ev = match_a;
    s_next.cmpb_ev = match_b;
    if (force_a || match_a) begin
      // force and a same-cycle match share one update, so the action happens once
      s_next.wave_a = wave_match(s_reg.wave_a, s_reg.ctrl_a_act[7:6],
                                 is_fast, is_phase,
                                 s_reg.ctrl_b_act[ATC_CB_WAVE_HI],
                                 s_reg.count_down);
    end
    if (force_b || match_b) begin
      s_next.wave_b = wave_match(s_reg.wave_b, s_reg.ctrl_a_act[5:4],
                                 is_fast, is_phase, 1'b0,
                                 s_reg.count_down);
    end

    // holding to working transfer on the timer source edge
    if (s_reg.async_sel && src_tick) begin
      if (s_reg.busy[ATC_BUSY_COUNTER]) begin
        s_next.cnt = s_reg.cnt_hold;
      end
      if (s_reg.busy[ATC_BUSY_COMPARE_A]) begin
        s_next.cmpa_buf = s_reg.cmpa_hold;
      end
      if (s_reg.busy[ATC_BUSY_COMPARE_B]) begin
        s_next.cmpb_buf = s_reg.cmpb_hold;
      end
      if (s_reg.busy[ATC_BUSY_CONTROL_A]) begin
        s_next.ctrl_a_act = s_reg.ctrl_a_hold;
      end
      if (s_reg.busy[ATC_BUSY_CONTROL_B]) begin
        s_next.ctrl_b_act = s_reg.ctrl_b_hold;
      end
      s_next.busy = '0;
    end

    // software writes; a write in a transfer cycle sets busy again
    if (wr_ca) begin
      s_next.ctrl_a_hold = reg_wdata & ATC_CA_READ_MASK;
      if (s_reg.async_sel) begin
        s_next.busy[ATC_BUSY_CONTROL_A] = 1'b1;
      end else begin
        s_next.ctrl_a_act = reg_wdata & ATC_CA_READ_MASK;
      end
    end
    if (wr_cb) begin
      s_next.ctrl_b_hold = reg_wdata[3:0] & ATC_CB_KEEP_MASK;
      if (s_reg.async_sel) begin
        s_next.busy[ATC_BUSY_CONTROL_B] = 1'b1;
      end else begin
        s_next.ctrl_b_act = reg_wdata[3:0];
      end
    end
    if (wr_cnt) begin
      s_next.block_match = 1'b1;
      s_next.cnt_hold = reg_wdata;
      if (s_reg.async_sel) begin
        s_next.busy[ATC_BUSY_COUNTER] = 1'b1;
      end else begin
        s_next.cnt = reg_wdata;
      end
    end
    if (wr_a) begin
      s_next.cmpa_hold = reg_wdata;
      if (s_reg.async_sel) begin
        s_next.busy[ATC_BUSY_COMPARE_A] = 1'b1;
      end else begin
        s_next.cmpa_buf = reg_wdata;
      end
    end
    if (wr_b) begin
      s_next.cmpb_hold = reg_wdata;
      if (s_reg.async_sel) begin
        s_next.busy[ATC_BUSY_COMPARE_B] = 1'b1;
      end else begin
        s_next.cmpb_buf = reg_wdata;
      end
    end
    if (wr_as) begin
      s_next.ext_clk = reg_wdata[ATC_AS_EXT_CLK];
      s_next.async_sel = reg_wdata[ATC_AS_ASYNC_SEL];
      if (reg_wdata[ATC_AS_ASYNC_SEL] != s_reg.async_sel) begin
        // pending transfers are dropped; contents are undefined anyway
        s_next.busy = '0;
      end
    end
    if (!is_pwm) begin
      s_next.cmpa_use = s_next.cmpa_buf;
      s_next.cmpb_use = s_next.cmpb_buf;
    end

    // read data, one cycle after the strobe
    s_next.rdata = ATC_RESET_BYTE;
    if (reg_rd) begin
      if (reg_addr == ATC_OFS_CONTROL_A) begin
        s_next.rdata = s_reg.ctrl_a_hold & ATC_CA_READ_MASK;
      end else if (reg_addr == ATC_OFS_CONTROL_B) begin
        s_next.rdata = {4'h0, s_reg.ctrl_b_hold};
      end else if (reg_addr == ATC_OFS_COUNTER) begin
        s_next.rdata = s_reg.cnt;
      end else if (reg_addr == ATC_OFS_COMPARE_A) begin
        s_next.rdata = s_reg.cmpa_hold;
      end else if (reg_addr == ATC_OFS_COMPARE_B) begin
        s_next.rdata = s_reg.cmpb_hold;
      end else if (reg_addr == ATC_OFS_ASYNC_STATUS) begin
        s_next.rdata = {1'b0, s_reg.ext_clk, s_reg.async_sel, s_reg.busy};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // =====================================================================
  // outputs
  assign reg_rdata = s_reg.rdata;
  assign crystal_osc_enable = ~s_reg.ext_clk;
  assign ext_clock_buffer_enable = s_reg.ext_clk & s_reg.async_sel;
  assign wave_out_a = s_reg.wave_a;
  assign wave_out_b = s_reg.wave_b;
  assign overflow_event = s_reg.ovf_ev;
  assign compare_a_event = s_reg.cmpa_ev;
  assign compare_b_event = s_reg.cmpb_ev;

  // =====================================================================
  // assertions
  property p_ctrl_a_rsvd;
    @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == ATC_OFS_CONTROL_A |=> reg_rdata[3:2] == 2'b00;
  endproperty
  a_ctrl_a_rsvd: assert property (p_ctrl_a_rsvd)
    else $error("control a reserved bits read nonzero");

  property p_ctrl_b_upper;
    @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == ATC_OFS_CONTROL_B |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_ctrl_b_upper: assert property (p_ctrl_b_upper)
    else $error("force strobes or reserved bits read nonzero");

  property p_normal_wrap;
    @(posedge ref_clk) disable iff (rst)
      cnt_tick && mode == ATC_MODE_NORMAL && s_reg.cnt == ATC_MAX && !wr_cnt
      && !(s_reg.async_sel && s_reg.busy[ATC_BUSY_COUNTER])
      |=> s_reg.cnt == ATC_BOTTOM ##0 overflow_event;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap)
    else $error("normal mode did not wrap with overflow at max");

  property p_ctc_clear;
    @(posedge ref_clk) disable iff (rst)
      cnt_tick && mode == ATC_MODE_CLEAR_ON_CMP && s_reg.cnt == s_reg.cmpa_use
      && !wr_cnt && !s_reg.async_sel |=> s_reg.cnt == ATC_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("clear-on-compare did not clear at compare a");

  property p_block_after_write;
    @(posedge ref_clk) disable iff (rst)
      s_reg.block_match && cnt_tick |=> !compare_a_event && !compare_b_event;
  endproperty
  a_block_after_write: assert property (p_block_after_write)
    else $error("compare event after counter write");

  property p_force_quiet;
    @(posedge ref_clk) disable iff (rst)
      force_a && !cnt_tick && !wr_cnt && !s_reg.busy[ATC_BUSY_COUNTER]
      |=> !compare_a_event ##0
      s_reg.cnt == $past(s_reg.cnt);
  endproperty
  a_force_quiet: assert property (p_force_quiet)
    else $error("forced compare raised event or moved counter");

  property p_force_toggle;
    @(posedge ref_clk) disable iff (rst)
      force_a && s_reg.ctrl_a_act[7:6] == ATC_ACT_TOGGLE
      |=> wave_out_a != $past(wave_out_a);
  endproperty
  a_force_toggle: assert property (p_force_toggle)
    else $error("forced toggle did not change wave a");

  property p_busy_set;
    @(posedge ref_clk) disable iff (rst)
      s_reg.async_sel && wr_cnt && !wr_as |=> s_reg.busy[ATC_BUSY_COUNTER];
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("counter busy not set by async write");

  property p_busy_clear;
    @(posedge ref_clk) disable iff (rst)
      s_reg.async_sel && src_tick && s_reg.busy[ATC_BUSY_COMPARE_A] && !wr_a
      |=> !s_reg.busy[ATC_BUSY_COMPARE_A]
          && s_reg.cmpa_buf == $past(s_reg.cmpa_hold);
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("compare a transfer or busy clear missed");

  property p_counter_read;
    @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == ATC_OFS_COUNTER |=> reg_rdata == $past(s_reg.cnt);
  endproperty
  a_counter_read: assert property (p_counter_read)
    else $error("counter read not live value");

  property p_stopped;
    @(posedge ref_clk) disable iff (rst)
      s_reg.ctrl_b_act[2:0] == 3'b000 && !s_reg.async_sel && !wr_cnt
      |=> s_reg.cnt == $past(s_reg.cnt);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

endmodule : atc_timer

// ---- dv/test_async_8bit_timer_control.sv ----
// bench for the 8-bit timer: register access, wave modes, prescaler,
// forced compares, counter-write suppression and pin-driven transfers
// assumes atc_pkg and atc_timer are compiled before this file
`timescale 1ns/1ps
module test_async_8bit_timer_control;
  import atc_pkg::*;
  // =====================================================================
  // stimulus and observation
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic timer_osc_in_pin = 1'b0;
  logic crystal_osc_enable;
  logic ext_clock_buffer_enable;
  logic wave_out_a;
  logic wave_out_b;
  logic overflow_event;
  logic compare_a_event;
  logic compare_b_event;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h0000_fff7;
  int n_cmp = 0;
  int n;
  int m;
  int i;
  int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] acts[4] = '{2'h2, 2'h1, 2'h3, 2'h1};
  logic expw[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] amap[7] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB6, 8'hB5};
  logic [7:0] d;
  logic [7:0] t;
  logic [7:0] got;

  always #5 ref_clk = ~ref_clk;

  atc_timer u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .timer_osc_in_pin(timer_osc_in_pin),
    .crystal_osc_enable(crystal_osc_enable),
    .ext_clock_buffer_enable(ext_clock_buffer_enable),
    .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b),
    .overflow_event(overflow_event),
    .compare_a_event(compare_a_event),
    .compare_b_event(compare_b_event)
  );

  // =====================================================================
  // event tally and hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (compare_a_event !== 1'b0 || compare_b_event !== 1'b0) begin
      n_cmp <= n_cmp + 1;
    end
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: run did not finish in time", $time);
      final_report();
    end
  end

  // =====================================================================
  // bus and check tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    chk(got, e);
  endtask : rchk

  // cycles until the chosen event: 0 overflow, 1 compare a, 2 compare b
  task automatic wait_ev(input int sel, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1 c = c + 1;
    end while (!((sel == 0 && overflow_event === 1'b1) ||
                 (sel == 1 && compare_a_event === 1'b1) ||
                 (sel == 2 && compare_b_event === 1'b1)) && c < 9000);
  endtask : wait_ev

  // compare a written in normal mode so it lands at once
  task automatic setup(input logic [2:0] md, input logic [2:0] cs,
                       input logic [7:0] top);
    wr(8'hB1, 8'h00);
    wr(8'hB0, 8'h00);
    wr(8'hB3, top);
    wr(8'hB2, 8'h00);
    wr(8'hB0, {6'h00, md[1:0]});
    wr(8'hB1, {4'h0, md[2], cs});
  endtask : setup

  function automatic int exp_per(input int md, input int top);
    case (md)
      1: return 510;
      5: return 2 * top;
      2, 7: return top + 1;
      default: return 256;
    endcase
  endfunction : exp_per

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // =====================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (amap[k]) rchk(amap[k], 8'h00);
    chk(crystal_osc_enable, 1'b1);
    chk(ext_clock_buffer_enable, 1'b0);
    repeat (4) begin
      d = $random(seed);
      wr(8'hB0, d);
      rchk(8'hB0, d & 8'hF3);
      // both force strobes set while the current mode is non-PWM; in PWM modes they follow d
      wr(8'hB1, d | (d[0] ? 8'h30 : 8'hF0));
      rchk(8'hB1, d & 8'h0F);
      wr(8'hB1, 8'h00);
      d = $random(seed);
      wr(8'hB2, d);
      rchk(8'hB2, d);
      wr(8'hB3, ~d);
      rchk(8'hB3, ~d);
      wr(8'hB4, d ^ 8'h5A);
      rchk(8'hB4, d ^ 8'h5A);
    end
    wr(8'hB5, 8'hFF);
    rchk(8'hB5, 8'h00);
    // every mode code, random top below max
    for (m = 0; m < 8; m++) begin
      d = $random(seed);
      t = 8'h08 + {1'b0, d[6:0]};
      setup(m[2:0], 3'h1, t);
      wait_ev(m == 2 ? 1 : 0, n);
      wait_ev(m == 2 ? 1 : 0, n);
      chk(n, exp_per(m, t));
    end
    // small clear-on-compare loop keeps the /1024 run short
    for (i = 1; i < 8; i++) begin
      setup(3'h2, i[2:0], 8'h03);
      wait_ev(1, n);
      wait_ev(1, n);
      chk(n, 4 * dv[i]);
    end
    // loaded while stopped, so no stray match lands before the start
    setup(3'h0, 3'h0, 8'h80);
    d = $random(seed);
    // keeps the first few counts clear of compare a
    d[7] = 1'b1;
    wr(8'hB4, d);
    wr(8'hB2, d);
    m = n_cmp;
    wr(8'hB1, 8'h01);
    repeat (4) @(posedge ref_clk);
    #1 chk(n_cmp - m, 0);
    wait_ev(2, n);
    // one full wrap plus the event register, less the cycles waited
    chk(n, 256 + 1 - 4);
    // fast mode: a compare write waits for the next bottom
    setup(3'h0, 3'h0, 8'h80);
    wr(8'hB4, 8'h10);
    wr(8'hB0, 8'h03);
    wr(8'hB2, 8'h20);
    wr(8'hB4, 8'h30);
    wr(8'hB1, 8'h01);
    wait_ev(2, n);
    // up from 0x20 to top, then from bottom to 0x30, plus the register
    chk(n, 256 - 32 + 48 + 1);
    // clear-on-compare with a nonzero count shows the force leaves it
    setup(3'h2, 3'h0, 8'h80);
    wr(8'hB2, 8'h5A);
    m = n_cmp;
    for (i = 0; i < 4; i++) begin
      wr(8'hB0, {acts[i], acts[i], 4'h2});
      wr(8'hB1, 8'hC0);
      @(posedge ref_clk);
      #1 chk(wave_out_a, expw[i]);
      chk(wave_out_b, expw[i]);
    end
    chk(n_cmp - m, 0);
    rchk(8'hB2, 8'h5A);
    rchk(8'hB1, 8'h00);
    // external clock enabled first, then oscillator-pin clocking
    wr(8'hB6, 8'h40);
    @(posedge ref_clk);
    #1 chk(crystal_osc_enable, 1'b0);
    chk(ext_clock_buffer_enable, 1'b0);
    wr(8'hB6, 8'h60);
    @(posedge ref_clk);
    #1 chk(ext_clock_buffer_enable, 1'b1);
    d = $random(seed);
    wr(8'hB2, d);
    wr(8'hB3, ~d);
    wr(8'hB4, d);
    wr(8'hB0, 8'h00);
    wr(8'hB1, 8'h00);
    rchk(8'hB6, 8'h7F);
    rchk(8'hB3, ~d);
    timer_osc_in_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    timer_osc_in_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rchk(8'hB6, 8'h60);
    rchk(8'hB2, d);
    // a pending counter transfer is dropped when async select changes
    wr(8'hB2, ~d);
    wr(8'hB6, 8'h00);
    rchk(8'hB6, 8'h00);
    chk(crystal_osc_enable, 1'b1);
    final_report();
  end
endmodule : test_async_8bit_timer_control
